// File: dsl_pkg.sv
// Shared constants and types of the serial channel loader.
// Assumes a single 200 MHz system clock; all pins are sampled in that domain.
package dsl_pkg;

  // ****************************************************************
  // Word layout
  // ****************************************************************
  localparam int NUM_CHAN = 32;
  localparam int ADDR_BITS = 5;
  localparam int CODE_BITS = 14;
  localparam int WORD_BITS = ADDR_BITS + CODE_BITS;
  localparam int SHIFT_BITS = WORD_BITS - 1;
  localparam int CNT_BITS = 5;
  // Address field sits above the code field in the received word
  localparam int ADDR_MSB = WORD_BITS - 1;
  localparam int ADDR_LSB = CODE_BITS;
  localparam int CODE_MSB = CODE_BITS - 1;

  // ****************************************************************
  // Counts and reset values
  // ****************************************************************
  localparam logic [CNT_BITS-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_BITS-1:0] CNT_ONE = 5'h01;
  // Index of the final bit of a frame (nineteenth bit)
  localparam logic [CNT_BITS-1:0] CNT_LAST = 5'h12;
  localparam logic [CODE_BITS-1:0] CODE_RESET = 14'h0000;
  localparam logic [SHIFT_BITS-1:0] SHIFT_RESET = 18'h0_0000;
  localparam logic [ADDR_BITS-1:0] ADDR_RESET = 5'h00;

  // ****************************************************************
  // Pin synchroniser lanes
  // ****************************************************************
  localparam int NUM_PINS = 4;
  localparam int PIN_FS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_DATA = 2;
  localparam int PIN_RST = 3;
  // Pulled-up pins idle high
  localparam logic [NUM_PINS-1:0] PIN_IDLE = 4'hF;

  typedef logic [CODE_BITS-1:0] dsl_code_t;
  typedef logic [ADDR_BITS-1:0] dsl_addr_t;
  typedef enum logic {ST_IDLE, ST_SHIFT} dsl_state_t;

endpackage : dsl_pkg

// File: dsl_wr_if.sv
// Write port between the frame decoder and the channel register bank.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface dsl_wr_if;
  import dsl_pkg::*;
  logic wr_en;
  dsl_addr_t addr;
  dsl_code_t code;
  logic clear;
  modport ctrl (output wr_en, output addr, output code, output clear);
  modport bank (input wr_en, input addr, input code, input clear);
endinterface : dsl_wr_if

// File: dsl_chan_bank.sv
// Bank of channel code registers, one per converter channel.
// Assumes writes come from the frame decoder on the same clock.
`timescale 1ns/10ps
module dsl_chan_bank
  import dsl_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Write port
  dsl_wr_if.bank wr,
  // Channel codes, each straight from its register
  output dsl_code_t chan_code [NUM_CHAN]
);

  // ****************************************************************
  // Per-channel registers
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
      logic hit;
      dsl_code_t code_q;
      // Address decode for this entry
      assign hit = wr.wr_en && (wr.addr == ADDR_BITS'(gi));
      // Zero on either reset; clear outranks a write in the same cycle
      always_ff @(posedge ref_clk) begin
        if (!rst_n || wr.clear) begin
          code_q <= CODE_RESET;
        end else if (hit) begin
          code_q <= wr.code;
        end
      end
      assign chan_code[gi] = code_q;
    end
  endgenerate

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_BANK_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr.wr_en && !wr.clear) |=> (chan_code[$past(wr.addr)] == $past(wr.code)))
    else $error("addressed channel did not take the code");
  AST_BANK_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr.clear |=> (chan_code[0] == CODE_RESET && chan_code[NUM_CHAN-1] == CODE_RESET))
    else $error("reset pin did not zero the channels");

endmodule : dsl_chan_bank

// File: dsl_serial_loader.sv
// Three-wire write-only serial loader for a 32-channel 14-bit converter.
// Assumes frame sync, serial clock, data and reset arrive as raw pins,
// asynchronous to ref_clk and much slower than it (serial clock <= ~30 MHz
// needs ref_clk well above four times that rate for clean edge finding).
`timescale 1ns/10ps

// How it works
// - Low frame sync opens a frame; bits taken on serial clock falling edges.
// - Each serial clock falling edge inside a frame shifts the data pin into the shift register.
// - A word is 19 bits, MSB first: five address bits, fourteen code bits.
// - Five address bits pick one of 32 channels, first bit is address MSB.
// - The fourteen code bits go into the addressed channel register.
// - Channel register loads only after all nineteen bits have arrived.
// - Code is unsigned straight binary from 0 to 16383.
// - All channel registers start at zero after power-on.
// - Reset pin low zeroes channels, counter and every other register except the pin synchronisers.
// - Works with a free-running or a gated serial clock.
// - Frame sync falling edge clears the bit counter.
// - Frame sync edges are ignored while a frame is still counting.
// - After nineteen bits, serial clock edges are ignored until a new frame.
// - Clock, data and reset pins idle high when left floating.
module dsl_serial_loader
  import dsl_pkg::*;
(
  // System clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Serial pins from the host
  input wire logic frame_sync_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic reset_pin_n,
  // Channel outputs
  output dsl_code_t chan_code [NUM_CHAN],
  // Load indication
  output logic load_pulse,
  output dsl_addr_t load_channel
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_s1;
  logic [NUM_PINS-1:0] pin_s2;
  logic [NUM_PINS-1:0] pin_s3;

  // Pins gathered into lanes
  assign pin_raw[PIN_FS] = frame_sync_n;
  assign pin_raw[PIN_SCLK] = serial_clk;
  assign pin_raw[PIN_DATA] = serial_data;
  assign pin_raw[PIN_RST] = reset_pin_n;

  // Two flops per pin, a third for edge finding; idle high like the pull-ups
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          pin_s1[gp] <= PIN_IDLE[gp];
          pin_s2[gp] <= PIN_IDLE[gp];
          pin_s3[gp] <= PIN_IDLE[gp];
        end else begin
          pin_s1[gp] <= pin_raw[gp];
          pin_s2[gp] <= pin_s1[gp];
          pin_s3[gp] <= pin_s2[gp];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Edge detection
  // ****************************************************************
  logic fs_fall;
  logic fs_rise;
  logic sclk_fall;
  logic din;
  logic pin_clear;
  logic clr;

  // Only the second and third stages are looked at
  assign fs_fall = pin_s3[PIN_FS] & ~pin_s2[PIN_FS];
  assign fs_rise = ~pin_s3[PIN_FS] & pin_s2[PIN_FS];
  // Falling edge only, whether the clock runs freely or in bursts
  assign sclk_fall = pin_s3[PIN_SCLK] & ~pin_s2[PIN_SCLK];
  // Data travels the same depth as the clock, so it lines up with its edge
  assign din = pin_s2[PIN_DATA];
  // Reset pin acts like the system reset on every register except the pin synchronisers
  assign pin_clear = ~pin_s2[PIN_RST];
  assign clr = !rst_n || pin_clear;

  // ****************************************************************
  // Frame decoder
  // ****************************************************************
  dsl_state_t state;
  dsl_state_t next_state;
  logic [CNT_BITS-1:0] bit_count;
  logic [CNT_BITS-1:0] next_count;
  logic [SHIFT_BITS-1:0] shift_reg;
  logic [SHIFT_BITS-1:0] next_shift;
  logic [WORD_BITS-1:0] next_word;
  logic start_frame;
  logic take_bit;
  logic last_bit;

  // A frame only opens from idle: sync edges inside a frame fall through
  assign start_frame = (state == ST_IDLE) && fs_fall;
  // Bits are taken only while counting; idle ignores the serial clock
  assign take_bit = (state == ST_SHIFT) && sclk_fall;
  assign last_bit = take_bit && (bit_count == CNT_LAST);
  // Newest bit enters at the bottom, so the first bit ends up as MSB
  assign next_word = {shift_reg, din};

  // Next bit count: cleared on frame start, stepped per bit taken
  assign next_count = start_frame ? CNT_ZERO :
                      take_bit ? (bit_count + CNT_ONE) : bit_count;

  // Next shift contents
  assign next_shift = start_frame ? SHIFT_RESET :
                      take_bit ? next_word[SHIFT_BITS-1:0] : shift_reg;

  // Sync rising early changes nothing; the frame ends on bit count alone
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_frame) begin
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (last_bit) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Decoder registers
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      state <= ST_IDLE;
      bit_count <= CNT_ZERO;
      shift_reg <= SHIFT_RESET;
    end else begin
      state <= next_state;
      bit_count <= next_count;
      shift_reg <= next_shift;
    end
  end

  // ****************************************************************
  // Channel write
  // ****************************************************************
  dsl_wr_if wr ();

  // Write fires once per full word; code kept as plain unsigned bits
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      wr.wr_en <= 1'b0;
      wr.addr <= ADDR_RESET;
      wr.code <= CODE_RESET;
    end else begin
      wr.wr_en <= last_bit;
      wr.addr <= next_word[ADDR_MSB:ADDR_LSB];
      wr.code <= next_word[CODE_MSB:0];
    end
  end
  assign wr.clear = pin_clear;

  // Load indication lines up with the channel register change
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      load_pulse <= 1'b0;
      load_channel <= ADDR_RESET;
    end else begin
      load_pulse <= wr.wr_en;
      load_channel <= wr.addr;
    end
  end

  // Register bank
  dsl_chan_bank u_bank (
    .ref_clk (ref_clk),
    .rst_n (rst_n),
    .wr (wr),
    .chan_code (chan_code)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence seq_last_bit;
    (state == ST_SHIFT) && sclk_fall && (bit_count == CNT_LAST) && !pin_clear;
  endsequence

  sequence seq_load;
    wr.wr_en ##1 load_pulse;
  endsequence

  AST_COUNT_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((state == ST_IDLE) && fs_fall && !pin_clear) |=>
      (state == ST_SHIFT && bit_count == CNT_ZERO && shift_reg == SHIFT_RESET))
    else $error("frame start did not clear the bit counter");

  AST_SHIFT_BIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((state == ST_SHIFT) && sclk_fall && (bit_count != CNT_LAST) && !pin_clear) |=>
      (shift_reg[0] == $past(din) && bit_count == $past(bit_count) + CNT_ONE))
    else $error("falling serial clock did not shift a bit");

  AST_LOAD_SEQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seq_last_bit |=> seq_load)
    else $error("last bit did not lead to a load two cycles on");

  AST_WORD_SPLIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seq_last_bit |=> (wr.addr == $past(shift_reg[SHIFT_BITS-1:CODE_BITS-1])
      && wr.code[0] == $past(din)))
    else $error("word was not split into address and code");

  AST_NO_EARLY_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr.wr_en |-> ($past(bit_count) == CNT_LAST && $past(state) == ST_SHIFT))
    else $error("channel written before nineteen bits");

  AST_IGNORE_FS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((state == ST_SHIFT) && (fs_fall || fs_rise) && !sclk_fall && !pin_clear) |=>
      (state == ST_SHIFT && bit_count == $past(bit_count)))
    else $error("frame sync edge disturbed a running frame");

  AST_IGNORE_SCLK: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((state == ST_IDLE) && sclk_fall && !fs_fall && !pin_clear) |=>
      (state == ST_IDLE && shift_reg == $past(shift_reg)) ##1 !wr.wr_en)
    else $error("serial clock acted after the frame ended");

  AST_EARLY_RISE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((state == ST_SHIFT) && fs_rise && !last_bit && !pin_clear) |=>
      (state == ST_SHIFT) ##1 !wr.wr_en)
    else $error("early frame sync rise ended the frame");

  AST_PIN_RESET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pin_clear |=> (state == ST_IDLE && bit_count == CNT_ZERO && !wr.wr_en && !load_pulse))
    else $error("reset pin did not clear the decoder");


  // ****************************************************************
  // Checks on outputs, reset and idle behaviour
  // ****************************************************************
  // Counting with no serial clock fall in view
  sequence seq_shift_wait;
    (state == ST_SHIFT) && !sclk_fall && !pin_clear;
  endsequence

  // Sitting idle with no sync fall in view
  sequence seq_idle_wait;
    (state == ST_IDLE) && !fs_fall && !pin_clear;
  endsequence

  AST_SHIFT_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seq_shift_wait |=>
      (state == ST_SHIFT && shift_reg == $past(shift_reg) && bit_count == $past(bit_count)))
    else $error("shift register moved without a serial clock fall");

  AST_IDLE_STAY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seq_idle_wait |=> (state == ST_IDLE && bit_count == $past(bit_count)))
    else $error("decoder left idle without a frame sync fall");

  AST_COUNT_MAX: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == ST_SHIFT) |-> (bit_count <= CNT_LAST))
    else $error("bit counter ran past the nineteenth bit");

  AST_FRAME_END: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seq_last_bit |=> (state == ST_IDLE && wr.wr_en))
    else $error("frame did not close after the nineteenth bit");

  AST_WORD_CODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seq_last_bit |=> (wr.code[CODE_MSB:1] == $past(shift_reg[CODE_MSB-1:0])))
    else $error("code field was not taken from the last fourteen bits");

  // Load outputs line up with the bank write they announce
  AST_LOAD_CHAN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    load_pulse |-> (load_channel == $past(wr.addr)))
    else $error("load channel differs from the written address");

  AST_LOAD_CODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    load_pulse |-> (chan_code[load_channel] == $past(wr.code)))
    else $error("loaded channel does not hold the written code");

  AST_PULSE_ONE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    load_pulse |=> !load_pulse)
    else $error("load pulse stood for more than one cycle");

  // Reset checks carry no disable, since reset is what triggers them
  AST_SYS_CLEAR: assert property (@(posedge ref_clk)
    !rst_n |=> (state == ST_IDLE && bit_count == CNT_ZERO && !load_pulse
      && chan_code[0] == CODE_RESET && chan_code[NUM_CHAN-1] == CODE_RESET))
    else $error("system reset did not clear the loader");

  AST_SYNC_IDLE: assert property (@(posedge ref_clk)
    !rst_n |=> (pin_s1 == PIN_IDLE && pin_s2 == PIN_IDLE && pin_s3 == PIN_IDLE))
    else $error("pin synchronisers did not settle at the pulled-up level");

endmodule : dsl_serial_loader

// File: dsl_host_model.sv
// Host model driving the three-wire write port of the serial loader.
// Assumes the loader samples these pins on its own clock; link period 160 ns.
`timescale 1ns/10ps
module dsl_host_model
  import dsl_pkg::*;
(
  // Serial pins towards the loader
  output logic frame_sync_n,
  output logic serial_clk,
  output logic serial_data
);
  // ************************************************
  // Link timing
  // ************************************************
  localparam real HALF_NS = 80.0;
  // Above the 280 ns minimum between writes
  localparam real GAP_NS = 300.0;

  // Pulled-up lines idle high
  initial begin
    frame_sync_n = 1'b1;
    serial_clk = 1'b1;
    serial_data = 1'b1;
  end

  // One frame: sync may rise after bit rise_at, pulse after bit glitch_at;
  // extra falls follow the word while sync stays low
  task automatic send(input logic [WORD_BITS-1:0] word, input int nbits,
                      input int rise_at, input int glitch_at, input int extra);
    int i;
    // Offset keeps pin changes off the system clock edges
    #1.7;
    frame_sync_n = 1'b0;
    #(HALF_NS);
    for (i = 0; i < nbits + extra; i++) begin
      // Data moves on the rising serial clock, MSB first
      serial_data = (i < WORD_BITS) ? word[WORD_BITS-1-i] : ~serial_data;
      #(HALF_NS);
      serial_clk = 1'b0;
      #(HALF_NS);
      serial_clk = 1'b1;
      if (i + 1 == rise_at) begin
        frame_sync_n = 1'b1;
      end
      if (i + 1 == glitch_at) begin
        frame_sync_n = 1'b1;
        #(HALF_NS);
        frame_sync_n = 1'b0;
      end
    end
    // Released data floats to its pull-up level
    serial_data = 1'b1;
    frame_sync_n = 1'b1;
    #(GAP_NS);
  endtask : send

  // Free-running clock with sync high; data toggles every cycle
  task automatic idle_clocks(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      serial_data = ~serial_data;
      #(HALF_NS);
      serial_clk = 1'b0;
      #(HALF_NS);
      serial_clk = 1'b1;
    end
    serial_data = 1'b1;
  endtask : idle_clocks
endmodule : dsl_host_model

// File: tb_dac_channel_serial_loader.sv
// Self-checking bench for the serial channel loader.
// Assumes the host model in its own file and a 200 MHz system clock.
`timescale 1ns/10ps
module tb_dac_channel_serial_loader
  import dsl_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reset_pin_n = 1'b1;
  logic frame_sync_n;
  logic serial_clk;
  logic serial_data;
  dsl_code_t chan_code [NUM_CHAN];
  logic load_pulse;
  dsl_addr_t load_channel;
  dsl_code_t exp_code [NUM_CHAN];
  dsl_addr_t last_chan;
  int n_loads = 0;
  int n_mismatch = 0;
  int n_tests = 0;

  // ************************************************
  // Clock, design and host
  // ************************************************
  always #2.5 ref_clk = ~ref_clk;

  dsl_serial_loader u_dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .frame_sync_n(frame_sync_n),
    .serial_clk(serial_clk),
    .serial_data(serial_data),
    .reset_pin_n(reset_pin_n),
    .chan_code(chan_code),
    .load_pulse(load_pulse),
    .load_channel(load_channel)
  );

  dsl_host_model u_host (
    .frame_sync_n(frame_sync_n),
    .serial_clk(serial_clk),
    .serial_data(serial_data)
  );

  // Loads counted mid-cycle, where the one-cycle pulse has settled
  always @(negedge ref_clk) begin
    if (load_pulse === 1'b1) begin
      n_loads <= n_loads + 1;
      last_chan <= load_channel;
    end
  end

  // ************************************************
  // Shared checks
  // ************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expd);
    n_tests++;
    if (seen !== expd) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, expd, seen);
    end
  endtask : check

  task automatic check_all();
    for (int i = 0; i < NUM_CHAN; i++) begin
      check($sformatf("chan_code[%0d]", i), chan_code[i], exp_code[i]);
    end
  endtask : check_all

  task automatic zero_exp();
    for (int i = 0; i < NUM_CHAN; i++) begin
      exp_code[i] = CODE_RESET;
    end
  endtask : zero_exp

  // Full frame, then exactly one load of the addressed channel
  task automatic write_word(input dsl_addr_t a, input dsl_code_t c, input int rise_at,
                            input int glitch_at, input int extra);
    int k;
    @(negedge ref_clk);
    n_loads = 0;
    u_host.send({a, c}, WORD_BITS, rise_at, glitch_at, extra);
    for (k = 0; k < 40 && n_loads == 0; k++) begin
      @(negedge ref_clk);
    end
    exp_code[a] = c;
    check("load count", n_loads, 1);
    check("load channel", last_chan, a);
    check_all();
  endtask : write_word

  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_codes();
    dsl_addr_t addrs [6] = '{5'h00, 5'h1F, 5'h10, 5'h01, 5'h05, 5'h0A};
    dsl_code_t codes [6] = '{14'h0000, 14'h3FFF, 14'h2000, 14'h0001, 14'h2AAA, 14'h1555};
    for (int i = 0; i < 6; i++) begin
      write_word(addrs[i], codes[i], WORD_BITS, 0, 0);
    end
  endtask : t_codes

  // Falls after the nineteenth and between frames change nothing
  task automatic t_extra_falls();
    write_word(5'h03, 14'h1234, 0, 0, 3);
    u_host.idle_clocks(5);
    repeat (10) @(negedge ref_clk);
    check("load count idle", n_loads, 1);
    check_all();
  endtask : t_extra_falls

  // Sync pulses mid-frame, and sync rising early, both leave the word whole
  task automatic t_sync_edges();
    write_word(5'h07, 14'h0ABC, WORD_BITS, 7, 0);
    write_word(5'h1E, 14'h3210, 10, 0, 0);
  endtask : t_sync_edges

  // Partial word loads nothing; reset pin clears all; next frame restarts
  task automatic t_partial_reset();
    @(negedge ref_clk);
    n_loads = 0;
    u_host.send({5'h02, 14'h3FFF}, 12, WORD_BITS, 0, 0);
    repeat (20) @(negedge ref_clk);
    check("load count partial", n_loads, 0);
    check_all();
    reset_pin_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    reset_pin_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    zero_exp();
    check_all();
    write_word(5'h02, 14'h0155, WORD_BITS, 0, 0);
  endtask : t_partial_reset

  // System reset in mid-run zeroes every channel
  task automatic t_sys_reset();
    rst_n = 1'b0;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    zero_exp();
    check_all();
  endtask : t_sys_reset

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    zero_exp();
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    check_all();
    t_codes();
    t_extra_falls();
    t_sync_edges();
    t_partial_reset();
    t_sys_reset();
    final_report();
  end

  // Whole run is near 38 us; this cuts a hang well past it
  initial begin
    #200_000;
    n_mismatch++;
    final_report();
  end
endmodule : tb_dac_channel_serial_loader
